// >>> design/plc_regs.svh
// Constants of the port LED and low-speed output controller
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
`define PLC_CLK_PERIOD_PS 64'd4000
`define PLC_BLINK_UNIT_PS 64'd2500000000
`define PLC_BLINK_UNIT_CYC (`PLC_BLINK_UNIT_PS / `PLC_CLK_PERIOD_PS)
`define PLC_BLINK_MIN_UNITS 8'h01
`define PLC_BLINK_MAX_UNITS 8'hff
`define PLC_PWM_MAX 8'hff
`define PLC_PWM_STEP_CYC 4
`define PLC_LS_OE_RST 8'h00
`define PLC_LS_VAL_RST 8'h55
`define PLC_MAX_PORTS 28
`define PLC_PORTS_PER_DEV 2
`define PLC_LEDS_PER_PORT 4
`define PLC_LS_PER_PORT 4
`define PLC_DEV_ID_W 4
`endif

// >>> design/plc_pkg.sv
// Types of the port LED and low-speed output controller
package plc_pkg;
   typedef enum logic [1:0] {
      LED_OFF,
      LED_ON,
      LED_PWM,
      LED_BLINK
   } led_mode_t;

   typedef enum logic [1:0] {
      SCOPE_PORT,
      SCOPE_DEVICE,
      SCOPE_SYSTEM
   } ls_scope_t;

   typedef struct packed {
      led_mode_t mode;
      logic [7:0] intensity;
      logic [7:0] on_time;
      logic [7:0] off_time;
   } led_cfg_t;

   typedef struct packed {
      logic valid;
      logic oe_we;
      logic val_we;
      ls_scope_t scope;
      logic [3:0] dev;
      logic port;
      logic [3:0] oe;
      logic [3:0] val;
   } ls_wr_t;
endpackage : plc_pkg

// >>> design/port_led_and_output_control.sv
// LED drivers, blink clock sharing and low-speed outputs of two ports
//
// Function
// - Strap picks serial or SPI host mode
// - Device id lets 14 devices share host
// - Only LED outputs blink or dim
// - LED outputs active low
// - LED pins float in reset, then high
// - Each LED: on, off, PWM or blink
// - Separate blink on/off times, 2.5-637.5 ms
// - 256 intensity levels, 0 off, 255 brightest
// - Intensity resets to zero
// - Blink timing shared by all ports
// - SPI mode: source or take shared clock
// - Chain mode: first sources, others repeat
// - Low-speed outputs can drive static LEDs
// - Low-speed writes: port, device or system
// - Low-speed enables reset to disabled
// - Values reset first 1, second 0
`timescale 1ns/1ps
`include "plc_regs.svh"
module port_led_and_output_control #(
   parameter int UNIT_CYCLES = int'(`PLC_BLINK_UNIT_CYC),
   parameter int PWM_STEP = `PLC_PWM_STEP_CYC,
   parameter int NLED = `PLC_PORTS_PER_DEV * `PLC_LEDS_PER_PORT
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic enable_pin_i,
   input wire logic host_spi_strap_i,
   input wire logic [3:0] dev_id_i,
   input wire logic share_source_i,
   input wire logic chain_first_i,
   input plc_pkg::led_cfg_t led_cfg_i [NLED],
   input plc_pkg::ls_wr_t ls_wr_i,
   input wire logic blink_clock_share_pin_i,
   output logic blink_clock_share_pin_o,
   output logic blink_clock_share_pin_oe_n_o,
   input wire logic chain_clock_input_pin_i,
   output logic chain_clock_output_pin_o,
   output logic [NLED-1:0] led_drive_o,
   output logic [NLED-1:0] led_drive_oe_n_o,
   output logic [7:0] lowspeed_out_o,
   output logic [7:0] lowspeed_out_oe_n_o,
   output logic host_spi_mode_o
);
   import plc_pkg::*;

   localparam int UW = $clog2(UNIT_CYCLES);
   localparam int PW = (PWM_STEP > 1) ? $clog2(PWM_STEP) : 1;

   if (UNIT_CYCLES < 2 || NLED != 8 || PWM_STEP < 1) begin : g_bad_param
      $error("Needs UNIT_CYCLES >= 2, PWM_STEP >= 1 and NLED of 8");
   end

   // Pins from outside: enable, strap, shared clock, chain clock
   logic [3:0] sync1;
   logic [3:0] sync2;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {chain_clock_input_pin_i, blink_clock_share_pin_i,
                   host_spi_strap_i, enable_pin_i};
         sync2 <= sync1;
      end
   end

   // Run state, strap capture and external clock edge
   logic run, spi_mode, ext_prev, use_int, ext_clk;
   logic next_run, next_spi_mode, next_ext_prev;
   logic [1:0] strap_age, next_strap_age;
   always_comb begin
      next_run = sync2[0];
      // Strap is read once, on the edge after it has crossed both flops
      next_strap_age = (strap_age == 2'd3) ? strap_age : strap_age + 2'd1;
      next_spi_mode = (strap_age == 2'd2) ? sync2[1] : spi_mode;
      use_int = spi_mode ? share_source_i : chain_first_i;
      ext_clk = spi_mode ? sync2[2] : sync2[3];
      next_ext_prev = ext_clk;
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run <= 1'b0;
         strap_age <= 2'd0;
         spi_mode <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         run <= next_run;
         strap_age <= next_strap_age;
         spi_mode <= next_spi_mode;
         ext_prev <= next_ext_prev;
      end
   end
   assign host_spi_mode_o = spi_mode;

   // Internal LED clock: one period per 2.5 ms blink unit
   logic [UW-1:0] unit_cnt, next_unit_cnt;
   logic int_wrap, int_clk, tick;
   always_comb begin
      int_wrap = (unit_cnt == UW'(UNIT_CYCLES - 1));
      int_clk = (unit_cnt < UW'(UNIT_CYCLES / 2));
      next_unit_cnt = (!run || int_wrap) ? '0 : unit_cnt + 1'b1;
      // One time base for every LED keeps both ports in step
      tick = run && (use_int ? int_wrap : (ext_clk && !ext_prev));
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unit_cnt <= '0;
      end else begin
         unit_cnt <= next_unit_cnt;
      end
   end

   // Clock sharing pins
   logic share_out, share_oe_n, chain_out;
   logic next_share_out, next_share_oe_n, next_chain_out;
   always_comb begin
      next_share_out = int_clk;
      next_share_oe_n = !(run && spi_mode && share_source_i);
      if (!run || spi_mode) begin
         next_chain_out = 1'b0;
      end else if (chain_first_i) begin
         next_chain_out = int_clk;
      end else begin
         // Repeated clock lags the input by the two synchroniser flops plus the output flop
         next_chain_out = sync2[3];
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         share_out <= 1'b0;
         share_oe_n <= 1'b1;
         chain_out <= 1'b0;
      end else begin
         share_out <= next_share_out;
         share_oe_n <= next_share_oe_n;
         chain_out <= next_chain_out;
      end
   end
   assign blink_clock_share_pin_o = share_out;
   assign blink_clock_share_pin_oe_n_o = share_oe_n;
   assign chain_clock_output_pin_o = chain_out;

   // PWM time base
   logic [PW-1:0] step_cnt, next_step_cnt;
   logic [7:0] pwm_cnt, next_pwm_cnt;
   logic step;
   always_comb begin
      step = (step_cnt == PW'(PWM_STEP - 1));
      next_step_cnt = step ? '0 : step_cnt + 1'b1;
      next_pwm_cnt = step ? pwm_cnt + 8'h01 : pwm_cnt;
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_cnt <= '0;
         pwm_cnt <= 8'h00;
      end else begin
         step_cnt <= next_step_cnt;
         pwm_cnt <= next_pwm_cnt;
      end
   end

   // Per LED blink phase and unit count
   logic [NLED-1:0] phase_on;
   logic [7:0] blink_cnt [NLED];
   logic [NLED-1:0] pwm_on;
   genvar gi;
   for (gi = 0; gi < NLED; gi++) begin : g_led
      logic next_phase;
      logic [7:0] next_cnt;
      logic [7:0] limit;
      always_comb begin
         limit = phase_on[gi] ? led_cfg_i[gi].on_time
                              : led_cfg_i[gi].off_time;
         // A zero time acts as the one-unit minimum
         if (limit < `PLC_BLINK_MIN_UNITS) begin
            limit = `PLC_BLINK_MIN_UNITS;
         end
         next_phase = phase_on[gi];
         next_cnt = blink_cnt[gi];
         if (!run || led_cfg_i[gi].mode != LED_BLINK) begin
            next_phase = 1'b1;
            next_cnt = 8'h00;
         end else if (tick) begin
            if (blink_cnt[gi] + 8'h01 >= limit) begin
               next_phase = !phase_on[gi];
               next_cnt = 8'h00;
            end else begin
               next_cnt = blink_cnt[gi] + 8'h01;
            end
         end
         // 0 never lights, 255 lights 255 of 256 slots
         pwm_on[gi] = led_cfg_i[gi].intensity > pwm_cnt;
      end
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            phase_on[gi] <= 1'b1;
            blink_cnt[gi] <= 8'h00;
         end else begin
            phase_on[gi] <= next_phase;
            blink_cnt[gi] <= next_cnt;
         end
      end
   end

   // LED drive pins, low means lit
   logic [NLED-1:0] led_drive, led_oe_n;
   logic [NLED-1:0] next_led_drive, next_led_oe_n;
   always_comb begin
      next_led_oe_n = {NLED{!run}};
      for (int i = 0; i < NLED; i++) begin
         unique case (led_cfg_i[i].mode)
            LED_ON: next_led_drive[i] = 1'b0;
            LED_OFF: next_led_drive[i] = 1'b1;
            LED_PWM: next_led_drive[i] = !pwm_on[i];
            LED_BLINK: next_led_drive[i] =
               !(phase_on[i] && pwm_on[i]);
         endcase
         if (!run) begin
            next_led_drive[i] = 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_drive <= {NLED{1'b1}};
         led_oe_n <= {NLED{1'b1}};
      end else begin
         led_drive <= next_led_drive;
         led_oe_n <= next_led_oe_n;
      end
   end
   assign led_drive_o = led_drive;
   assign led_drive_oe_n_o = led_oe_n;

   // Low-speed outputs: static levels only
   function automatic logic ls_hit(ls_wr_t w, logic [3:0] id, logic p);
      return w.valid && (w.scope == SCOPE_SYSTEM ||
             (w.dev == id && (w.scope == SCOPE_DEVICE || w.port == p)));
   endfunction : ls_hit

   logic [7:0] ls_oe, ls_val;
   logic [7:0] next_ls_oe, next_ls_val;
   always_comb begin
      next_ls_oe = ls_oe;
      next_ls_val = ls_val;
      if (!run) begin
         next_ls_oe = `PLC_LS_OE_RST;
         next_ls_val = `PLC_LS_VAL_RST;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (ls_hit(ls_wr_i, dev_id_i, 1'(p))) begin
               if (ls_wr_i.oe_we) begin
                  next_ls_oe[p*4 +: 4] = ls_wr_i.oe;
               end
               if (ls_wr_i.val_we) begin
                  next_ls_val[p*4 +: 4] = ls_wr_i.val;
               end
            end
         end
      end
   end
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ls_oe <= `PLC_LS_OE_RST;
         ls_val <= `PLC_LS_VAL_RST;
      end else begin
         ls_oe <= next_ls_oe;
         ls_val <= next_ls_val;
      end
   end
   // Value and enable apply together on a write; values first is safest
   assign lowspeed_out_o = ls_val;
   assign lowspeed_out_oe_n_o = ~ls_oe;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_blink_end;
      run && tick && led_cfg_i[2].mode == LED_BLINK && phase_on[2] &&
      blink_cnt[2] + 8'h01 >= led_cfg_i[2].on_time &&
      led_cfg_i[2].on_time != 8'h00;
   endsequence
   sequence s_sys_wr;
      run && ls_wr_i.valid && ls_wr_i.oe_we &&
      ls_wr_i.scope == SCOPE_SYSTEM;
   endsequence

   chk_led_float_reset: assert property (
      !run |=> &led_drive_oe_n_o && &led_drive_o)
      else $error("LED pins not floating while held in reset");
   chk_led_on_low: assert property (
      run && led_cfg_i[0].mode == LED_ON |=>
      !led_drive_o[0] && !led_drive_oe_n_o[0])
      else $error("LED on mode did not drive low");
   chk_led_off_high: assert property (
      run && led_cfg_i[1].mode == LED_OFF |=> led_drive_o[1])
      else $error("LED off mode did not drive high");
   chk_pwm_zero_dark: assert property (
      led_cfg_i[5].mode == LED_PWM && led_cfg_i[5].intensity == 8'h00
      |=> led_drive_o[5])
      else $error("Zero intensity lit the LED");
   chk_pwm_full_lit: assert property (
      run && led_cfg_i[5].mode == LED_PWM &&
      led_cfg_i[5].intensity == 8'hff && pwm_cnt != 8'hff
      |=> !led_drive_o[5])
      else $error("Full intensity left the LED dark");
   chk_blink_phase_flip: assert property (
      s_blink_end |=> !phase_on[2] && blink_cnt[2] == 8'h00)
      else $error("Blink on phase did not end on time");
   chk_blink_off_high: assert property (
      run && led_cfg_i[2].mode == LED_BLINK && !phase_on[2]
      |=> led_drive_o[2])
      else $error("Blink off phase drove low");
   chk_ls_reset_vals: assert property (
      $rose(run) |-> ls_oe == 8'h00 && ls_val == 8'h55)
      else $error("Low-speed outputs left reset with wrong values");
   chk_ls_broadcast: assert property (
      s_sys_wr |=> ls_oe == {2{$past(ls_wr_i.oe)}})
      else $error("System write did not reach both ports");
   chk_share_drive: assert property (
      run && spi_mode && share_source_i |=> !share_oe_n)
      else $error("Source device not driving shared clock");
   chk_chain_repeat: assert property (
      run && !spi_mode && !chain_first_i
      |=> chain_out == $past(sync2[3]))
      else $error("Chain clock not repeated");
endmodule : port_led_and_output_control

// >>> dv/blink_clock_partner.sv
// Far-side LED clock source standing in for the other devices
`timescale 1ns/1ps
module blink_clock_partner (
   input wire logic run_i,
   output logic clk_o
);
   // Stands low while stopped so no stray unit tick reaches the block
   initial clk_o = 1'b0;
   always begin
      #62.5;
      clk_o = run_i ? ~clk_o : 1'b0;
   end
endmodule : blink_clock_partner

// >>> dv/port_led_and_output_control_tb.sv
// Self-checking bench for the LED and low-speed output controller
`timescale 1ns/1ps
module port_led_and_output_control_tb;
   import plc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic en = 1'b1;
   logic strap = 1'b1;
   logic src = 1'b1;
   logic first = 1'b1;
   logic prun = 1'b0;
   logic ext, sh_o, sh_oe_n, ch_o, spi;
   led_cfg_t cfg [8];
   ls_wr_t w = '0;
   logic [7:0] drv, drv_oe_n, ls, ls_oe_n;
   logic [7:0] ev = 8'h55;
   logic [7:0] eo = 8'h00;
   logic [31:0] r = 32'h7fafcd96;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int c_led, c_sh, c_ch, c_rise;
   int ta [3] = '{3, 255, 1};
   int tb [3] = '{5, 1, 1};
   logic [7:0] pv [4];

   always #2 sys_clk_i = ~sys_clk_i;
   initial foreach (cfg[k]) cfg[k] = '{LED_OFF, 8'h00, 8'h01, 8'h01};

   blink_clock_partner ext_src (.run_i(prun), .clk_o(ext));

   port_led_and_output_control #(.UNIT_CYCLES(8), .PWM_STEP(1)) DUT (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .enable_pin_i(en),
      .host_spi_strap_i(strap), .dev_id_i(4'h5), .share_source_i(src),
      .chain_first_i(first), .led_cfg_i(cfg), .ls_wr_i(w),
      .blink_clock_share_pin_i(sh_oe_n === 1'b0 ? sh_o : ext),
      .blink_clock_share_pin_o(sh_o),
      .blink_clock_share_pin_oe_n_o(sh_oe_n),
      .chain_clock_input_pin_i(ext), .chain_clock_output_pin_o(ch_o),
      .led_drive_o(drv), .led_drive_oe_n_o(drv_oe_n),
      .lowspeed_out_o(ls), .lowspeed_out_oe_n_o(ls_oe_n),
      .host_spi_mode_o(spi));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // Lit cycles of a 2048-cycle window with eight clocks per unit
   function automatic int blink_lit(input int a, input int b);
      return 2048 / ((a + b) * 8) * a * 8;
   endfunction : blink_lit

   task automatic chk(input logic [7:0] g, input logic [7:0] e,
                      input string m);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask : chk

   task automatic rng(input int g, input int lo, input int hi,
                      input string m);
      n_compared++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("mismatch at %0t: %s got %0d", $time, m, g);
      end
   endtask : rng

   task automatic give_verdict;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic set_led(input int i, input led_mode_t m,
                          input logic [7:0] v, a, b);
      @(negedge sys_clk_i);
      cfg[i] = '{m, v, a, b};
   endtask : set_led

   task automatic watch(input int i, input int n);
      logic pc;
      c_led = 0;
      c_sh = 0;
      c_ch = 0;
      c_rise = 0;
      pc = ch_o;
      repeat (n) begin
         @(negedge sys_clk_i);
         c_led += int'(drv[i] === 1'b0);
         c_sh += int'(sh_o === 1'b1);
         c_ch += int'(ch_o === 1'b1);
         c_rise += int'(ch_o === 1'b1 && pc === 1'b0);
         pc = ch_o;
      end
   endtask : watch

   // Checks the previous write's effect, then offers the next one
   task automatic ls_put(input ls_wr_t x);
      @(negedge sys_clk_i);
      chk(ls, ev, "ls value");
      chk(ls_oe_n, ~eo, "ls enable");
      w = x;
      if (x.valid && (x.scope == SCOPE_SYSTEM || x.dev == 4'h5))
         for (int p = 0; p < 2; p++)
            if (x.scope != SCOPE_PORT || x.port == p[0]) begin
               if (x.oe_we) eo[p*4+:4] = x.oe;
               if (x.val_we) ev[p*4+:4] = x.val;
            end
   endtask : ls_put

   task automatic do_reset;
      rst_n_i = 1'b0;
      repeat (12) @(negedge sys_clk_i);
      chk(drv_oe_n, 8'hff, "reset float");
      chk(ls_oe_n, 8'hff, "reset ls enable");
      chk(ls, 8'h55, "reset ls value");
      rst_n_i = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      chk(drv_oe_n, 8'h00, "run drive");
      chk(drv, 8'hff, "run high");
      chk({7'h00, spi}, {7'h00, strap}, "strap");
      ev = 8'h55;
      eo = 8'h00;
      $display("reset test done");
   endtask : do_reset

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      do_reset();
      for (int i = 0; i < 8; i++) begin
         set_led(i, LED_ON, 8'h00, 8'h01, 8'h01);
         repeat (2) @(negedge sys_clk_i);
         chk(drv, ~(8'h01 << i), "led on");
         set_led(i, LED_OFF, 8'h00, 8'h01, 8'h01);
      end
      $display("on off test done");
      r = lfsr(r);
      pv = '{8'h00, 8'hff, r[7:0], 8'h80};
      foreach (pv[k]) begin
         set_led(5, LED_PWM, pv[k], 8'h01, 8'h01);
         repeat (2) @(negedge sys_clk_i);
         watch(5, 256);
         rng(c_led, int'(pv[k]), int'(pv[k]), "pwm");
      end
      set_led(5, LED_OFF, 8'h00, 8'h01, 8'h01);
      $display("pwm test done");
      for (int k = 0; k < 3; k++) begin
         set_led(2, LED_OFF, 8'h00, 8'h01, 8'h01);
         set_led(2, LED_BLINK, 8'hff, 8'(ta[k]), 8'(tb[k]));
         repeat (4) @(negedge sys_clk_i);
         watch(2, 2048);
         rng(c_led, blink_lit(ta[k], tb[k]) - 8, blink_lit(ta[k], tb[k]),
             "blink");
         rng(c_sh, 1024, 1024, "share out");
         rng(c_ch, 0, 0, "chain idle");
      end
      set_led(2, LED_BLINK, 8'h00, 8'h03, 8'h05);
      watch(2, 512);
      rng(c_led, 0, 0, "blink dark");
      $display("blink test done");
      src = 1'b0;
      prun = 1'b1;
      set_led(2, LED_OFF, 8'h00, 8'h01, 8'h01);
      set_led(2, LED_BLINK, 8'hff, 8'h01, 8'h01);
      repeat (8) @(negedge sys_clk_i);
      watch(2, 500);
      chk({7'h00, sh_oe_n}, 8'h01, "share released");
      rng(c_led, 240, 256, "ext blink");
      prun = 1'b0;
      repeat (8) @(negedge sys_clk_i);
      set_led(2, LED_OFF, 8'h00, 8'h01, 8'h01);
      set_led(2, LED_BLINK, 8'hff, 8'h01, 8'h01);
      repeat (4) @(negedge sys_clk_i);
      watch(2, 300);
      rng(c_led, 297, 300, "ext held");
      set_led(2, LED_OFF, 8'h00, 8'h01, 8'h01);
      $display("shared clock test done");
      // Values go out before enables, as a careful host would do
      ls_put('{1'b1, 1'b0, 1'b1, SCOPE_SYSTEM, 4'h0, 1'b0, 4'h0,
               4'ha});
      ls_put('{1'b1, 1'b1, 1'b0, SCOPE_DEVICE, 4'h5, 1'b0, 4'hf, 4'h0});
      ls_put('{1'b1, 1'b1, 1'b1, SCOPE_PORT, 4'h3, 1'b1, 4'h0, 4'h0});
      repeat (40) begin
         r = lfsr(r);
         ls_put('{r[0] | r[1], r[2], r[3], ls_scope_t'(r[5:4] % 2'd3),
                  r[6] ? 4'h5 : r[11:8], r[12], r[16:13], r[20:17]});
      end
      ls_put('0);
      $display("low-speed test done");
      en = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk(drv_oe_n, 8'hff, "enable low float");
      chk(ls_oe_n, 8'hff, "enable low ls");
      chk(ls, 8'h55, "enable low value");
      en = 1'b1;
      $display("enable test done");
      strap = 1'b0;
      do_reset();
      set_led(2, LED_BLINK, 8'hff, 8'h03, 8'h05);
      repeat (4) @(negedge sys_clk_i);
      watch(2, 2048);
      rng(c_ch, 1024, 1024, "chain source");
      rng(c_rise, 256, 256, "chain edges");
      chk({7'h00, sh_oe_n}, 8'h01, "share float");
      first = 1'b0;
      prun = 1'b1;
      repeat (8) @(negedge sys_clk_i);
      watch(2, 500);
      rng(c_rise, 15, 17, "chain repeat");
      $display("chain test done");
      give_verdict();
   end
endmodule : port_led_and_output_control_tb
